// ---- rtl/slcr_defs.vh ----
// Purpose: constants of the sensor link configuration register bank
// Assumes: 16-bit registers, 6-bit register addresses, 20 MHz mclk
// Notes: definitions only
`ifndef SLCR_DEFS_VH
`define SLCR_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define SLCR_ADDR_GENCFG 6'h01
`define SLCR_ADDR_CHCTL 6'h02
`define SLCR_ADDR_NOP 6'h03

// ****************************************
// Reset values
// ****************************************
`define SLCR_RST_GENCFG 16'h8000
`define SLCR_RST_CHCTL 16'h0442
`define SLCR_RST_NOP 16'h0000

// ****************************************
// Writable bit masks (reserved bits clear)
// ****************************************
`define SLCR_MASK_GENCFG 16'hFFDF
`define SLCR_MASK_CHCTL 16'h077B

// ****************************************
// General configuration fields
// ****************************************
`define SLCR_GC_PAR 15
`define SLCR_GC_MUXDIS 14
`define SLCR_GC_CH2_BUF 13
`define SLCR_GC_CH2_SRC_HI 12
`define SLCR_GC_CH2_SRC_LO 11
`define SLCR_GC_CH2_METH 10
`define SLCR_GC_CH1_BUF 9
`define SLCR_GC_CH1_SRC_HI 8
`define SLCR_GC_CH1_SRC_LO 7
`define SLCR_GC_CH1_METH 6
`define SLCR_GC_CLK_HI 4
`define SLCR_GC_CLK_LO 3
`define SLCR_GC_SIDG 2
`define SLCR_GC_CRC 1
`define SLCR_GC_VSEL 0

// ****************************************
// Channel control fields
// ****************************************
`define SLCR_CC_REG_ON 10
`define SLCR_CC_CH2_TRG_HI 9
`define SLCR_CC_CH2_TRG_LO 8
`define SLCR_CC_CH2_ALLOW 6
`define SLCR_CC_CH2_ON 5
`define SLCR_CC_CH1_TRG_HI 4
`define SLCR_CC_CH1_TRG_LO 3
`define SLCR_CC_CH1_ALLOW 1
`define SLCR_CC_CH1_ON 0

// ****************************************
// Field codes
// ****************************************
`define SLCR_SRC_SOFT 2'b01
`define SLCR_SRC_AUTO 2'b10
`define SLCR_TRG_SHORT 2'b01
`define SLCR_TRG_LONG 2'b10
`define SLCR_CLK_1M 2'b01
`define SLCR_CLK_4M 2'b10

// ****************************************
// Timing
// ****************************************
`define SLCR_CLK_HZ 20000000
`define SLCR_PAR_PERIOD_US 150
// Scaled per microsecond first: the plain product overflows 32-bit integers
`define SLCR_PAR_PERIOD_CYC (`SLCR_PAR_PERIOD_US * (`SLCR_CLK_HZ / 1000000))

`endif

// ---- rtl/slcr_chan.v ----
// Purpose: decode one channel's sync settings and soft trigger
// Assumes: all inputs on mclk; fields already registered
// Notes: instantiated once for each sensor channel
`timescale 1ns/1ps
`default_nettype none
`include "slcr_defs.vh"

module slcr_chan (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Configuration fields
	input wire buf_sets_length,
	input wire [1:0] trigger_source,
	input wire sync_method,
	input wire line_on,
	input wire pulse_allow,
	// Soft trigger write event
	input wire trig_wr,
	input wire [1:0] soft_trigger,
	// Decoded outputs
	output reg src_pin,
	output reg src_soft,
	output reg src_auto,
	output reg buf_len,
	output reg pulse_width,
	output reg sync_short,
	output reg sync_long,
	output reg sync_buf
);

	// ****************************************
	// Combinational decode
	// ****************************************
	reg next_buf_len;
	reg soft_ok;

	// Automatic mode forces buffer control of the length
	always @* begin
		next_buf_len = buf_sets_length |
			(trigger_source == `SLCR_SRC_AUTO);
		soft_ok = trig_wr & line_on & pulse_allow &
			(trigger_source == `SLCR_SRC_SOFT);
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	// Soft trigger pulses last one cycle: one request per write
	always @(posedge mclk) begin
		if (!nrst) begin
			src_pin <= 1'b1;
			src_soft <= 1'b0;
			src_auto <= 1'b0;
			buf_len <= 1'b0;
			pulse_width <= 1'b0;
			sync_short <= 1'b0;
			sync_long <= 1'b0;
			sync_buf <= 1'b0;
		end else begin
			src_soft <= (trigger_source == `SLCR_SRC_SOFT);
			src_auto <= (trigger_source == `SLCR_SRC_AUTO);
			src_pin <= (trigger_source[1] == trigger_source[0]);
			buf_len <= next_buf_len;
			// Method only counts under buffer control
			pulse_width <= next_buf_len & sync_method;
			// Buffer length makes both codes equal
			sync_buf <= soft_ok & next_buf_len &
				(soft_trigger[1] ^ soft_trigger[0]);
			sync_short <= soft_ok & ~next_buf_len &
				(soft_trigger == `SLCR_TRG_SHORT);
			sync_long <= soft_ok & ~next_buf_len &
				(soft_trigger == `SLCR_TRG_LONG);
		end
	end

endmodule // slcr_chan
`default_nettype wire

// ---- rtl/slcr_regs.v ----
// Purpose: configuration and channel control register bank
// Assumes: host port decoded upstream into strobes on mclk
// Notes: reads return data one cycle after the read strobe
//
// Overview of operation
// - Access classes RO (no-op status) and RW supported.
// - Locked config accepts writes until end command.
// - Parity checked every 150 us, fault sets.
// - Bit 15 parity; reset 0x8000.
// - Bit 14 set disables address multiplexing.
// - Bit 13 buffer sets ch2 length; auto forces.
// - Bits 12:11 pick ch2 trigger source.
// - Bit 10 ch2 method, only under buffer.
// - Channel 1 mirrors using bits 9..6.
// - Bits 4:3 pick external clock rate.
// - Bit 2 enables sensor-ID use, some payloads.
// - Bit 1 picks sensor or own CRC.
// - Bit 0 picks 5.3 or 7.6 V.
// - Channel control bit 10 regulator on, reset 1.
// - Soft trigger fields: short, long or none.
// - Soft trigger ignored when off, once per write.
// - Buffer length makes short and long equal.
// - Pulse allow bits reset to one.
// - Line on bits 5 and 0, reset 0.
// - No-operation write changes nothing, returns status.
// - Host uses serial or direct control path.
`timescale 1ns/1ps
`default_nettype none
`include "slcr_defs.vh"

module slcr_regs (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Host register port, one path chosen by the host
	input wire wr_en,
	input wire rd_en,
	input wire [5:0] addr,
	input wire [15:0] wr_data,
	input wire end_programming_command,
	input wire [15:0] global_status,
	output reg [15:0] rd_data,
	output reg rd_valid,
	output reg addr_err,
	// Lock and fault state
	output reg program_locked_config,
	output reg parity_fault,
	// General configuration outputs
	output reg address_mux_disable,
	output reg [1:0] external_clock_select,
	output reg sensor_id_flag_use,
	output reg check_bits_source,
	output reg supply_voltage_select,
	// Channel control outputs
	output reg supply_regulator_on,
	output reg ch1_line_on,
	output reg ch2_line_on,
	output reg ch1_pulse_allow,
	output reg ch2_pulse_allow,
	// Channel 1 decoded sync control
	output wire ch1_src_pin,
	output wire ch1_src_soft,
	output wire ch1_src_auto,
	output wire ch1_buf_len,
	output wire ch1_pulse_width,
	output wire ch1_sync_short,
	output wire ch1_sync_long,
	output wire ch1_sync_buf,
	// Channel 2 decoded sync control
	output wire ch2_src_pin,
	output wire ch2_src_soft,
	output wire ch2_src_auto,
	output wire ch2_buf_len,
	output wire ch2_pulse_width,
	output wire ch2_sync_short,
	output wire ch2_sync_long,
	output wire ch2_sync_buf
);

	// ****************************************
	// Register storage
	// ****************************************
	reg [15:0] general_configuration;
	reg [15:0] channel_control;
	reg trig_wr;
	reg [23:0] par_cnt;
	reg [15:0] next_rd_data;
	reg next_addr_err;
	wire wr_gc;
	wire wr_cc;

	// Locked config silently drops late writes
	assign wr_gc = wr_en & (addr == `SLCR_ADDR_GENCFG) &
		~program_locked_config;
	assign wr_cc = wr_en & (addr == `SLCR_ADDR_CHCTL);

	// ****************************************
	// Programming lock
	// ****************************************
	// Lock is sticky until reset; only the end command sets it
	always @(posedge mclk) begin
		if (!nrst) begin
			program_locked_config <= 1'b0;
		end else if (end_programming_command) begin
			program_locked_config <= 1'b1;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	// Reserved bits masked so they always read zero
	always @(posedge mclk) begin
		if (!nrst) begin
			general_configuration <= `SLCR_RST_GENCFG;
			channel_control <= `SLCR_RST_CHCTL;
			trig_wr <= 1'b0;
		end else begin
			if (wr_gc) begin
				general_configuration <= wr_data &
					`SLCR_MASK_GENCFG;
			end
			if (wr_cc) begin
				channel_control <= wr_data &
					`SLCR_MASK_CHCTL;
			end
			// One-cycle event: triggers act once per write
			trig_wr <= wr_cc;
		end
	end

	// ****************************************
	// Periodic parity check
	// ****************************************
	// Fault is sticky; only reset clears it, as nothing else is given
	always @(posedge mclk) begin
		if (!nrst) begin
			par_cnt <= 24'h00_0000;
			parity_fault <= 1'b0;
		end else if (par_cnt == (`SLCR_PAR_PERIOD_CYC - 1)) begin
			par_cnt <= 24'h00_0000;
			// Odd parity expected over all sixteen bits
			if (~(^general_configuration)) begin
				parity_fault <= 1'b1;
			end
		end else begin
			par_cnt <= par_cnt + 24'h00_0001;
		end
	end

	// ****************************************
	// Field outputs
	// ****************************************
	// Registered copies keep outputs straight from flip-flops
	always @(posedge mclk) begin
		if (!nrst) begin
			address_mux_disable <= 1'b0;
			external_clock_select <= 2'b00;
			sensor_id_flag_use <= 1'b0;
			check_bits_source <= 1'b0;
			supply_voltage_select <= 1'b0;
			supply_regulator_on <= 1'b1;
			ch1_line_on <= 1'b0;
			ch2_line_on <= 1'b0;
			ch1_pulse_allow <= 1'b1;
			ch2_pulse_allow <= 1'b1;
		end else begin
			address_mux_disable <=
				general_configuration[`SLCR_GC_MUXDIS];
			// Codes 00 and 11 both mean no external clock
			external_clock_select <=
				general_configuration[`SLCR_GC_CLK_HI:`SLCR_GC_CLK_LO] ^
				{2{general_configuration[`SLCR_GC_CLK_HI] &
				general_configuration[`SLCR_GC_CLK_LO]}};
			sensor_id_flag_use <=
				general_configuration[`SLCR_GC_SIDG];
			check_bits_source <=
				general_configuration[`SLCR_GC_CRC];
			supply_voltage_select <=
				general_configuration[`SLCR_GC_VSEL];
			supply_regulator_on <=
				channel_control[`SLCR_CC_REG_ON];
			ch1_line_on <= channel_control[`SLCR_CC_CH1_ON];
			ch2_line_on <= channel_control[`SLCR_CC_CH2_ON];
			ch1_pulse_allow <= channel_control[`SLCR_CC_CH1_ALLOW];
			ch2_pulse_allow <= channel_control[`SLCR_CC_CH2_ALLOW];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// No-op returns global status and stores nothing
	always @* begin
		next_rd_data = 16'h0000;
		next_addr_err = 1'b0;
		case (addr)
			`SLCR_ADDR_GENCFG: begin
				next_rd_data = general_configuration;
			end
			`SLCR_ADDR_CHCTL: begin
				next_rd_data = channel_control;
			end
			`SLCR_ADDR_NOP: begin
				next_rd_data = global_status;
			end
			default: begin
				next_addr_err = 1'b1;
			end
		endcase
	end

	// Answer on reads and no-op writes alike
	always @(posedge mclk) begin
		if (!nrst) begin
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			addr_err <= 1'b0;
		end else begin
			rd_valid <= rd_en | (wr_en & (addr == `SLCR_ADDR_NOP));
			addr_err <= (rd_en | wr_en) & next_addr_err;
			if (rd_en | (wr_en & (addr == `SLCR_ADDR_NOP))) begin
				rd_data <= next_rd_data;
			end
		end
	end

	// ****************************************
	// Per-channel sync decode
	// ****************************************
	slcr_chan u_ch1 (
		.mclk(mclk),
		.nrst(nrst),
		.buf_sets_length(general_configuration[`SLCR_GC_CH1_BUF]),
		.trigger_source(general_configuration[`SLCR_GC_CH1_SRC_HI:
			`SLCR_GC_CH1_SRC_LO]),
		.sync_method(general_configuration[`SLCR_GC_CH1_METH]),
		.line_on(channel_control[`SLCR_CC_CH1_ON]),
		.pulse_allow(channel_control[`SLCR_CC_CH1_ALLOW]),
		.trig_wr(trig_wr),
		.soft_trigger(channel_control[`SLCR_CC_CH1_TRG_HI:
			`SLCR_CC_CH1_TRG_LO]),
		.src_pin(ch1_src_pin),
		.src_soft(ch1_src_soft),
		.src_auto(ch1_src_auto),
		.buf_len(ch1_buf_len),
		.pulse_width(ch1_pulse_width),
		.sync_short(ch1_sync_short),
		.sync_long(ch1_sync_long),
		.sync_buf(ch1_sync_buf)
	);

	slcr_chan u_ch2 (
		.mclk(mclk),
		.nrst(nrst),
		.buf_sets_length(general_configuration[`SLCR_GC_CH2_BUF]),
		.trigger_source(general_configuration[`SLCR_GC_CH2_SRC_HI:
			`SLCR_GC_CH2_SRC_LO]),
		.sync_method(general_configuration[`SLCR_GC_CH2_METH]),
		.line_on(channel_control[`SLCR_CC_CH2_ON]),
		.pulse_allow(channel_control[`SLCR_CC_CH2_ALLOW]),
		.trig_wr(trig_wr),
		.soft_trigger(channel_control[`SLCR_CC_CH2_TRG_HI:
			`SLCR_CC_CH2_TRG_LO]),
		.src_pin(ch2_src_pin),
		.src_soft(ch2_src_soft),
		.src_auto(ch2_src_auto),
		.buf_len(ch2_buf_len),
		.pulse_width(ch2_pulse_width),
		.sync_short(ch2_sync_short),
		.sync_long(ch2_sync_long),
		.sync_buf(ch2_sync_buf)
	);

endmodule // slcr_regs
`default_nettype wire

// ---- tb/slcr_host.sv ----
// Purpose: host model driving the register port
// Assumes: one access in flight, launched just after mclk rises
// Notes: released lines show inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module slcr_host (
	// Clock
	input wire logic mclk,
	// Register port
	output logic wr_en,
	output logic rd_en,
	output logic [5:0] addr,
	output logic [15:0] wr_data,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic addr_err
);
	// Idle port; this path is the only control path
	initial begin
		wr_en = 0;
		rd_en = 0;
		addr = 6'h00;
		wr_data = 16'h0000;
	end
	// One write, then lines inverted so old data cannot pass
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr_en <= 1;
		addr <= a;
		wr_data <= d;
		@(posedge mclk);
		wr_en <= 0;
		addr <= ~a;
		wr_data <= ~d;
	endtask
	// Config write with odd parity placed in bit 15
	task automatic wcfg(input logic [14:0] d);
		wr(6'h01, {~^d, d});
	endtask
	// One read, answer waited for under a bound
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge mclk);
		rd_en <= 1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 0;
		addr <= ~a;
		d = 16'hxxxx;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			if (rd_valid || addr_err) begin
				d = rd_data;
				break;
			end
		end
	endtask
endmodule // slcr_host
`default_nettype wire

// ---- tb/slcr_regs_properties.sv ----
// Purpose: port-level assertions of the register bank
// Assumes: single mclk domain, synchronous active-low reset
// Notes: bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module slcr_regs_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Host port
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [5:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] global_status,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic addr_err,
	// State and decoded fields
	input wire logic program_locked_config,
	input wire logic parity_fault,
	input wire logic supply_regulator_on,
	input wire logic ch1_line_on,
	input wire logic ch2_line_on,
	input wire logic ch1_pulse_allow,
	input wire logic ch1_src_soft,
	input wire logic ch1_sync_long,
	input wire logic ch2_src_auto,
	input wire logic ch2_buf_len,
	input wire logic ch2_pulse_width,
	input wire logic ch2_sync_short,
	input wire logic ch2_sync_long,
	input wire logic ch2_sync_buf
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Register port answers
	a_read_answer: assert property (
		rd_en && addr inside {6'h01, 6'h02} |=> rd_valid)
		else $error("mapped read not answered");
	a_unmapped_err: assert property (
		rd_en && !(addr inside {6'h01, 6'h02, 6'h03})
		|=> addr_err && rd_data == 16'h0000)
		else $error("unmapped read not refused");
	a_nop_status: assert property (
		wr_en && addr == 6'h03
		|=> rd_valid && rd_data == $past(global_status))
		else $error("no-op write lacks status");
	// Channel control copies land two cycles after the write
	a_chctl_copy: assert property (
		wr_en && addr == 6'h02 |-> ##2
		supply_regulator_on == $past(wr_data[10], 2) &&
		ch2_line_on == $past(wr_data[5], 2) &&
		ch1_line_on == $past(wr_data[0], 2))
		else $error("channel control copy wrong");
	// Trigger gating and buffer length handling
	a_trig_gate: assert property (
		ch1_sync_long |-> ch1_line_on && ch1_pulse_allow && ch1_src_soft)
		else $error("pulse without its conditions");
	a_buf_equal: assert property (
		ch2_sync_buf || ch2_sync_short || ch2_sync_long
		|-> ch2_sync_buf == ch2_buf_len)
		else $error("buffer length pulse kind wrong");
	a_auto_forces: assert property (
		ch2_src_auto |-> ch2_buf_len)
		else $error("auto source without buffer length");
	a_method_gate: assert property (
		ch2_pulse_width |-> ch2_buf_len)
		else $error("method active without buffer length");
	// Sticky state until reset
	a_lock_sticky: assert property (
		program_locked_config |=> program_locked_config)
		else $error("lock dropped");
	a_fault_sticky: assert property (
		parity_fault |=> parity_fault)
		else $error("parity fault dropped");
endmodule // slcr_regs_properties
bind slcr_regs slcr_regs_properties chk_u (.*);
`default_nettype wire

// ---- tb/slcr_regs_test.sv ----
// Purpose: self-checking bench for the register bank
// Assumes: host model issues every register access
// Notes: parity period kept at its full 3000 cycles
`timescale 1ns/1ps
`default_nettype none
module slcr_regs_test;
	// Clock, reset and side inputs
	logic mclk = 0;
	logic nrst = 0;
	logic end_programming_command = 0;
	logic [15:0] global_status = 16'h5A3C;
	logic [15:0] d;
	int bad_count = 0;
	int comparisons = 0;
	int n_long = 0;
	int n_short = 0;
	int n_buf = 0;
	// Design port nets
	wire wr_en, rd_en, rd_valid, addr_err, program_locked_config;
	wire parity_fault, address_mux_disable, sensor_id_flag_use;
	wire check_bits_source, supply_voltage_select, supply_regulator_on;
	wire ch1_line_on, ch2_line_on, ch1_pulse_allow, ch2_pulse_allow;
	wire ch1_src_pin, ch1_src_soft, ch1_src_auto, ch1_buf_len;
	wire ch1_pulse_width, ch1_sync_short, ch1_sync_long, ch1_sync_buf;
	wire ch2_src_pin, ch2_src_soft, ch2_src_auto, ch2_buf_len;
	wire ch2_pulse_width, ch2_sync_short, ch2_sync_long, ch2_sync_buf;
	wire [5:0] addr;
	wire [15:0] wr_data, rd_data;
	wire [1:0] external_clock_select;
	always #25 mclk = ~mclk;
	slcr_regs dut_u (.*);
	slcr_host host_u (.*);
	// Count trigger pulses; each lasts one cycle
	always @(posedge mclk) begin
		n_long <= n_long + ch1_sync_long;
		n_short <= n_short + ch1_sync_short;
		n_buf <= n_buf + ch2_sync_buf;
	end
	task automatic chk(input string s, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog, well past the roughly 6100 cycles of the run
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1;
		host_u.rd(6'h01, d);
		chk("gencfg reset", 16'h8000, d);
		host_u.rd(6'h02, d);
		chk("chctl reset", 16'h0442, d);
		chk("regulator", 16'h0001, supply_regulator_on);
		chk("pin source", 16'h0003, {ch2_src_pin, ch1_src_pin});
		host_u.rd(6'h03, d);
		chk("nop status", 16'h5A3C, d);
		$display("test reset done");
		host_u.wcfg(15'h7FFF);
		host_u.rd(6'h01, d);
		chk("gencfg rw", 16'h7FDF, d);
		chk("fields", 16'h003C, {address_mux_disable, sensor_id_flag_use,
			check_bits_source, supply_voltage_select,
			external_clock_select});
		for (int k = 1; k < 3; k++) begin
			host_u.wcfg(15'(k << 3));
			host_u.rd(6'h05, d);
			chk("unmapped", 16'h0000, d);
			chk("clock", 16'(k), external_clock_select);
		end
		$display("test fields done");
		// Ch1 soft source; ch2 soft source under buffer, width method
		host_u.wcfg(15'h2C80);
		host_u.wr(6'h02, 16'h0573);
		host_u.wr(6'h02, 16'h0472);
		host_u.wr(6'h03, 16'h0000);
		host_u.rd(6'h02, d);
		chk("chctl after nop", 16'h0472, d);
		chk("long pulses", 16'h0001, 16'(n_long));
		chk("buffer pulses", 16'h0001, 16'(n_buf));
		chk("ch2 method", 16'h0001, ch2_pulse_width);
		// Ch1 on with its pulse allow bit kept set, short code
		host_u.wr(6'h02, 16'h040B);
		host_u.rd(6'h02, d);
		chk("short pulses", 16'h0001, 16'(n_short));
		host_u.wcfg(15'h1000);
		host_u.rd(6'h01, d);
		chk("auto buffer", 16'h0001, ch2_buf_len);
		$display("test triggers done");
		repeat (3001) @(posedge mclk);
		chk("no fault", 16'h0000, parity_fault);
		host_u.wr(6'h01, 16'h0003);
		repeat (3002) @(posedge mclk);
		chk("parity fault", 16'h0001, parity_fault);
		$display("test parity done");
		@(posedge mclk);
		end_programming_command <= 1;
		@(posedge mclk);
		end_programming_command <= 0;
		host_u.wcfg(15'h0004);
		host_u.rd(6'h01, d);
		chk("locked", 16'h0003, d);
		chk("lock flag", 16'h0001, program_locked_config);
		$display("test lock done");
		stop_test;
	end
endmodule // slcr_regs_test
`default_nettype wire
